// [bench/pin_mux_chk.sv]
/*
  Concurrent checks on the wires between the transceiver and MAC ends.
  Assumes clk_en is held high, so every edge after reset release counts.
*/
`timescale 1ns/1ps
module pin_mux_chk (
  // Clock and reset
  input wire logic       sys_clk,
  input wire logic       rst_n,
  // Transceiver drive
  input wire logic [3:0] phy_rxd_o,
  input wire logic       phy_rxdv_o,
  input wire logic       phy_rxer_o,
  input wire logic       phy_rx_oe,
  input wire logic       phy_rxc_o,
  input wire logic       phy_rxc_oe,
  input wire logic       phy_txc_o,
  input wire logic       phy_txc_oe,
  // MAC drive
  input wire logic       mac_txc_o,
  input wire logic       mac_txc_oe,
  input wire logic       mdc,
  input wire logic       mac_mdio_o
);
  // --------------------------------------------------------------------
  // Edges since reset release
  // --------------------------------------------------------------------
  // Saturates so a long run never wraps back into the settle window.
  logic [3:0] run_cnt;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      run_cnt <= 4'h0;
    end else if (run_cnt != 4'hF) begin
      run_cnt <= run_cnt + 4'h1;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence rxc_flip;
    $changed(phy_rxc_o);
  endsequence
  sequence rxc_hold_flip;
    $stable(phy_rxc_o) [*4] ##1 $changed(phy_rxc_o);
  endsequence
  sequence mdc_hold;
    $stable(mdc) [*4];
  endsequence

  chk_quiet_settle: assert property (
    run_cnt < 4'h4 |-> !phy_rx_oe && !phy_rxc_oe && !phy_txc_oe)
    else $error("Pin driven before straps settled.");
  chk_drive_holds: assert property (
    phy_rx_oe |=> phy_rx_oe)
    else $error("Receive pin drive dropped while running.");
  chk_clk_gated: assert property (
    phy_rxc_oe || phy_txc_oe |-> phy_rx_oe)
    else $error("Clock driven while receive pins isolated.");
  chk_txc_single: assert property (
    !(phy_txc_oe && mac_txc_oe))
    else $error("Both ends drive the transmit clock pin.");
  chk_txc_same: assert property (
    phy_txc_oe |-> phy_rxc_oe && phy_txc_o == phy_rxc_o)
    else $error("Transmit clock differs from receive clock.");
  chk_rxc_rate: assert property (
    phy_txc_oe && $changed(phy_rxc_o) |=> rxc_flip or rxc_hold_flip)
    else $error("Receive clock half period wrong.");
  chk_ref_toggle: assert property (
    mac_txc_oe && $past(mac_txc_oe) |-> $changed(mac_txc_o))
    else $error("Reference clock did not toggle.");
  chk_mdc_high: assert property (
    $rose(mdc) |=> mdc_hold ##1 $fell(mdc))
    else $error("Management clock high phase wrong.");
  chk_mdc_low: assert property (
    $fell(mdc) |=> mdc_hold ##1 $rose(mdc))
    else $error("Management clock low phase wrong.");
  chk_mdio_on_fall: assert property (
    $changed(mac_mdio_o) |-> $fell(mdc))
    else $error("Management data moved off the falling clock.");
  chk_rx_on_fall: assert property (
    phy_txc_oe && $changed({phy_rxd_o, phy_rxdv_o, phy_rxer_o})
    |-> $fell(phy_rxc_o))
    else $error("Receive pins moved off the falling clock.");
endmodule : pin_mux_chk

// [bench/tb.sv]
/*
  Self-checking bench joining both pin ends through the pin interface.
  Assumes the design files and the shared defines header are compiled.
*/
`timescale 1ns/1ps
`include "pin_mux_defs.svh"
module tb;
  logic                        sys_clk = 1'b0;
  logic                        rst_n = 1'b0;
  logic                        clk_en = 1'b1;
  logic                        rmii_select = 1'b0;
  logic                        speed_100 = 1'b1;
  pin_mux_pkg::iface_mode_type mode = pin_mux_pkg::MODE_MII;
  logic [4:1]                  mgmt_address;
  logic                        pcs_loopback, serial_iface_select_strap;
  logic                        isolate, straps_valid, rx_take, tx_take;
  logic [3:0]                  core_rx_data = 4'h0;
  logic                        core_rx_valid = 1'b0, core_rx_error = 1'b0;
  logic [3:0]                  core_tx_data, mac_rx_data;
  logic                        core_tx_en, core_tx_err, core_tx_sync;
  logic                        tx_strobe, mgmt_bit, mgmt_strobe;
  logic [3:0]                  mac_tx_data = 4'h0;
  logic                        mac_tx_en = 1'b0, mac_tx_err = 1'b0;
  logic                        mac_tx_sync = 1'b0;
  logic                        mdio_out = 1'b0, mdio_drive = 1'b0;
  logic                        mac_rx_valid, mac_rx_error, rx_strobe;
  int                          errors = 0;
  int                          compares = 0;

  mac_phy_pins_if pins ();

  phy_pin_end u_phy_pin_end (
    .sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en),
    .rmii_select(rmii_select), .speed_100(speed_100),
    .mgmt_address(mgmt_address), .pcs_loopback(pcs_loopback),
    .serial_iface_select_strap(serial_iface_select_strap),
    .isolate(isolate), .straps_valid(straps_valid),
    .rx_data(core_rx_data), .rx_valid(core_rx_valid),
    .rx_error(core_rx_error), .rx_take(rx_take),
    .tx_data(core_tx_data), .tx_en(core_tx_en), .tx_err(core_tx_err),
    .tx_sync(core_tx_sync), .tx_strobe(tx_strobe),
    .mgmt_bit(mgmt_bit), .mgmt_strobe(mgmt_strobe), .pins(pins));

  mac_pin_end u_mac_pin_end (
    .sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .mode(mode),
    .tx_data(mac_tx_data), .tx_en(mac_tx_en), .tx_err(mac_tx_err),
    .tx_sync(mac_tx_sync), .tx_take(tx_take), .mdio_out(mdio_out),
    .mdio_drive(mdio_drive), .rx_data(mac_rx_data),
    .rx_valid(mac_rx_valid), .rx_error(mac_rx_error),
    .rx_strobe(rx_strobe), .pins(pins));

  pin_mux_chk u_chk (
    .sys_clk(sys_clk), .rst_n(rst_n), .phy_rxd_o(pins.phy_rxd_o),
    .phy_rxdv_o(pins.phy_rxdv_o), .phy_rxer_o(pins.phy_rxer_o),
    .phy_rx_oe(pins.phy_rx_oe), .phy_rxc_o(pins.phy_rxc_o),
    .phy_rxc_oe(pins.phy_rxc_oe), .phy_txc_o(pins.phy_txc_o),
    .phy_txc_oe(pins.phy_txc_oe), .mac_txc_o(pins.mac_txc_o),
    .mac_txc_oe(pins.mac_txc_oe), .mdc(pins.mdc),
    .mac_mdio_o(pins.mac_mdio_o));

  always #20 sys_clk = ~sys_clk;

  // --------------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------------
  task automatic tick();
    @(posedge sys_clk);
    #1;
  endtask : tick

  task automatic chk(input string name, input logic [7:0] exp,
                     input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  function automatic logic pick(input int sel);
    case (sel)
      0: pick = straps_valid;
      1: pick = rx_take;
      2: pick = rx_strobe;
      3: pick = tx_take;
      4: pick = tx_strobe;
      default: pick = mgmt_strobe;
    endcase
  endfunction : pick

  // Bounded wait; a pulse that never comes counts as a mismatch.
  task automatic await(input int sel, input int n);
    int i, k;
    for (k = 0; k < n; k++) begin
      i = 0;
      do begin
        tick();
        i++;
      end while (pick(sel) !== 1'b1 && i < 60);
      if (pick(sel) !== 1'b1) begin
        errors++;
        $display("ERROR pulse %0d expected 1 seen %b", sel, pick(sel));
      end
    end
  endtask : await

  task automatic do_reset(input logic [6:0] p, input logic rm,
                          input pin_mux_pkg::iface_mode_type m,
                          input logic sp);
    logic [1:0] td;
    td = (m != pin_mux_pkg::MODE_MII) ? 2'h1 : (p[6] ? 2'h0 : 2'h2);
    @(posedge sys_clk);
    rst_n <= 1'b0;
    {pins.pull_rxer, pins.pull_rxc, pins.pull_rxdv, pins.pull_rxd} <= p;
    rmii_select <= rm;
    mode <= m;
    speed_100 <= sp;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    await(0, 1);
    chk("mgmt_address", {4'h0, p[0], p[1], p[2], p[3]},
        8'(mgmt_address));
    chk("pcs_loopback", 8'(p[4]), 8'(pcs_loopback));
    chk("serial_sel", 8'(p[5]), 8'(serial_iface_select_strap));
    chk("isolate", 8'(p[6]), 8'(isolate));
    // Flip the board levels: captured values must not follow them.
    @(posedge sys_clk);
    {pins.pull_rxer, pins.pull_rxc, pins.pull_rxdv, pins.pull_rxd} <= ~p;
    repeat (6) tick();
    chk("straps_held", {1'h0, p[0], p[1], p[2], p[3], p[6:4]},
        {1'h0, mgmt_address, isolate, serial_iface_select_strap,
         pcs_loopback});
    chk("rx_drive", 8'(!p[6]), 8'(pins.phy_rx_oe));
    chk("txc_dir", 8'(td),
        8'({pins.phy_txc_oe, pins.mac_txc_oe}));
  endtask : do_reset

  task automatic rxc_period(input int exp);
    int   i, n, t0, t1;
    logic prev;
    n = 0;
    t0 = 0;
    t1 = 0;
    for (i = 0; i < 60; i++) begin
      prev = pins.rxc;
      tick();
      if (prev === 1'b0 && pins.rxc === 1'b1) begin
        if (n == 0) t0 = i;
        if (n == 1) t1 = i;
        n++;
      end
    end
    chk("rxc_period", 8'(exp), 8'(t1 - t0));
  endtask : rxc_period

  task automatic rx_xfer(input logic [3:0] d, input logic v, input logic e);
    logic [3:0] x, mk;
    mk = (mode == pin_mux_pkg::MODE_SMII) ? 4'h1 : 4'hF;
    x = (mode == pin_mux_pkg::MODE_RMII) ? {2'h0, d[1:0]} : d & mk;
    @(posedge sys_clk);
    core_rx_data <= d;
    core_rx_valid <= v;
    core_rx_error <= e;
    await(1, 1);
    chk("rxd_pin", 8'(x), 8'(pins.rxd & mk));
    await(2, 2);
    chk("mac_rx_data", 8'(x), 8'(mac_rx_data & mk));
    if (mode != pin_mux_pkg::MODE_SMII) begin
      chk("rxdv_pin", 8'(v), 8'(pins.rxdv));
      chk("rxer_pin", 8'(e), 8'(pins.rxer));
      chk("mac_rx_valid", 8'(v), 8'(mac_rx_valid));
      chk("mac_rx_error", 8'(e), 8'(mac_rx_error));
    end
  endtask : rx_xfer

  task automatic tx_xfer(input logic [3:0] d, input logic en, input logic er,
                         input logic sy);
    logic [3:0] x, mk;
    logic       sm;
    sm = (mode == pin_mux_pkg::MODE_SMII);
    mk = (mode == pin_mux_pkg::MODE_RMII) ? 4'h3 : 4'hF;
    x = sm ? {2'h0, sy, d[0]} : d & mk;
    @(posedge sys_clk);
    mac_tx_data <= d;
    mac_tx_en <= en;
    mac_tx_err <= er;
    mac_tx_sync <= sy;
    await(3, 1);
    chk("txd_pin", 8'(x), 8'(pins.txd & mk));
    if (!sm) chk("txen_pin", 8'(en), 8'(pins.txen));
    if (mode == pin_mux_pkg::MODE_MII) begin
      chk("txer_pin", 8'(er), 8'(pins.txer));
    end
    await(4, 2);
    chk("core_tx_data", 8'(x), 8'(core_tx_data & mk));
    chk("core_tx_sync", 8'(sm & sy), 8'(core_tx_sync));
    if (!sm) begin
      chk("core_tx_en", 8'(en), 8'(core_tx_en));
      chk("core_tx_err", 8'(er), 8'(core_tx_err));
    end
  endtask : tx_xfer

  task automatic mdio_xfer(input logic drv, input logic b);
    @(posedge sys_clk);
    mdio_drive <= drv;
    mdio_out <= b;
    await(5, 3);
    chk("mgmt_bit", 8'(drv ? b : 1'b1), 8'(mgmt_bit));
  endtask : mdio_xfer

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : complete_run

  // --------------------------------------------------------------------
  // Sequence of modes and transfers
  // --------------------------------------------------------------------
  initial begin
    {pins.pull_rxer, pins.pull_rxc, pins.pull_rxdv, pins.pull_rxd} = 7'h00;
    do_reset(7'h08, 1'b0, pin_mux_pkg::MODE_MII, 1'b1);
    rxc_period(2 * `RXC_100_HALF);
    rx_xfer(4'h5, 1'b1, 1'b0);
    rx_xfer(4'hA, 1'b0, 1'b1);
    tx_xfer(4'h9, 1'b1, 1'b0, 1'b0);
    tx_xfer(4'h6, 1'b0, 1'b1, 1'b0);
    mdio_xfer(1'b1, 1'b0);
    mdio_xfer(1'b1, 1'b1);
    mdio_xfer(1'b0, 1'b0);
    do_reset(7'h17, 1'b0, pin_mux_pkg::MODE_MII, 1'b0);
    rxc_period(2 * `RXC_10_HALF);
    rx_xfer(4'h3, 1'b1, 1'b1);
    do_reset(7'h02, 1'b1, pin_mux_pkg::MODE_RMII, 1'b1);
    rx_xfer(4'hE, 1'b1, 1'b0);
    tx_xfer(4'hD, 1'b1, 1'b0, 1'b0);
    do_reset(7'h29, 1'b0, pin_mux_pkg::MODE_SMII, 1'b1);
    rx_xfer(4'h7, 1'b1, 1'b0);
    tx_xfer(4'h1, 1'b0, 1'b0, 1'b1);
    tx_xfer(4'h0, 1'b0, 1'b0, 1'b0);
    do_reset(7'h45, 1'b0, pin_mux_pkg::MODE_MII, 1'b1);
    complete_run();
  end

  // The whole sequence needs a few hundred cycles; this leaves margin.
  initial begin
    #400000;
    errors++;
    $display("ERROR watchdog expected done seen hang");
    complete_run();
  end
endmodule : tb

// [rtl/mac_phy_pins_if.sv]
/*
  The MAC-side pins between transceiver and MAC, with wire resolution.
  Assumes the bench sets the pull_* strap levels; the mdio pull-up is built in here.
*/
`timescale 1ns/1ps
interface mac_phy_pins_if;
  // Transceiver drives, straps read back through the same wires.
  logic [3:0] phy_rxd_o;
  logic       phy_rxdv_o;
  logic       phy_rxer_o;
  logic       phy_rx_oe;
  logic       phy_rxc_o;
  logic       phy_rxc_oe;
  logic       phy_txc_o;
  logic       phy_txc_oe;
  // Board strap resistors, set by the bench.
  logic [3:0] pull_rxd;
  logic       pull_rxdv;
  logic       pull_rxc;
  logic       pull_rxer;
  // MAC drives.
  logic       mac_txc_o;
  logic       mac_txc_oe;
  logic [3:0] txd;
  logic       txen;
  logic       txer;
  logic       mdc;
  logic       mac_mdio_o;
  logic       mac_mdio_oe;
  // Resolved wire levels.
  logic [3:0] rxd;
  logic       rxdv;
  logic       rxer;
  logic       rxc;
  logic       txc;
  logic       mdio;

  assign rxd  = phy_rx_oe ? phy_rxd_o : pull_rxd;
  assign rxdv = phy_rx_oe ? phy_rxdv_o : pull_rxdv;
  assign rxer = phy_rx_oe ? phy_rxer_o : pull_rxer;
  assign rxc  = phy_rxc_oe ? phy_rxc_o : pull_rxc;
  assign txc  = phy_txc_oe ? phy_txc_o : (mac_txc_oe ? mac_txc_o : 1'b0);
  assign mdio = mac_mdio_oe ? mac_mdio_o : 1'b1;

  modport phy (
    output phy_rxd_o, phy_rxdv_o, phy_rxer_o, phy_rx_oe,
    output phy_rxc_o, phy_rxc_oe, phy_txc_o, phy_txc_oe,
    input  rxd, rxdv, rxer, rxc, txc, txd, txen, txer, mdc, mdio
  );

  modport mac (
    output mac_txc_o, mac_txc_oe, txd, txen, txer, mdc,
    output mac_mdio_o, mac_mdio_oe,
    input  rxd, rxdv, rxer, rxc, txc, mdio
  );
endinterface : mac_phy_pins_if

// [rtl/mac_pin_end.sv]
/*
  MAC end of the pin link: sources the reference clock in RMII and serial
  modes, drives transmit pins and management clock, samples receive pins.
  Assumes mode is static while running and user inputs are on sys_clk.
*/
`timescale 1ns/1ps
`include "pin_mux_defs.svh"
module mac_pin_end (
  // Clock, reset, enable
  input  wire logic                      sys_clk,
  input  wire logic                      rst_n,
  input  wire logic                      clk_en,
  // Configuration
  input  wire pin_mux_pkg::iface_mode_type mode,
  // Transmit side
  input  wire logic [3:0]                tx_data,
  input  wire logic                      tx_en,
  input  wire logic                      tx_err,
  input  wire logic                      tx_sync,
  output logic                           tx_take,
  // Management side
  input  wire logic                      mdio_out,
  input  wire logic                      mdio_drive,
  // Receive side
  output logic [3:0]                     rx_data,
  output logic                           rx_valid,
  output logic                           rx_error,
  output logic                           rx_strobe,
  // Pins
  mac_phy_pins_if.mac                    pins
);
  pin_mux_pkg::mac_regs_type r;
  pin_mux_pkg::mac_regs_type next_r;

  always_comb begin
    logic       mii;
    logic       smp;
    logic       upd;
    logic [7:0] half;
    next_r    = r;
    mii       = (mode == pin_mux_pkg::MODE_MII);
    half      = (mode == pin_mux_pkg::MODE_SMII) ? `SMII_REF_HALF
                                                 : `RMII_REF_HALF;
    next_r.txc_s = {r.txc_s[1:0], pins.txc};
    next_r.rxc_s = {r.rxc_s[1:0], pins.rxc};
    next_r.rx_s1 = {pins.rxer, pins.rxdv, pins.rxd};
    next_r.rx_s2 = r.rx_s1;
    next_r.ref_oe = !mii;
    upd = 1'b0;
    smp = 1'b0;
    if (mii) begin
      next_r.ref_clk = 1'b0;
      next_r.ref_cnt = 8'h00;
      upd = r.txc_s[2] & !r.txc_s[1];
      smp = r.rxc_s[1] & !r.rxc_s[2];
    end else if (r.ref_cnt >= half - 8'h01) begin
      next_r.ref_cnt = 8'h00;
      next_r.ref_clk = !r.ref_clk;
      upd = r.ref_clk;
      smp = !r.ref_clk;
    end else begin
      next_r.ref_cnt = r.ref_cnt + 8'h01;
    end
    next_r.tx_take = upd;
    if (upd) begin
      next_r.txen = tx_en;
      next_r.txer = tx_err;
      next_r.txd  = tx_data;
      if (mode == pin_mux_pkg::MODE_SMII) begin
        next_r.txd = {2'h0, tx_sync, tx_data[0]};
      end
    end
    next_r.rx_strobe = smp;
    if (smp) begin
      next_r.rx_data  = r.rx_s2[3:0];
      next_r.rx_valid = r.rx_s2[4];
      next_r.rx_error = r.rx_s2[5];
    end
    next_r.mdio_oe = mdio_drive;
    if (r.mdc_cnt >= `MDC_HALF - 8'h01) begin
      next_r.mdc_cnt = 8'h00;
      next_r.mdc     = !r.mdc;
      if (r.mdc) begin
        next_r.mdio_o = mdio_out;
      end
    end else begin
      next_r.mdc_cnt = r.mdc_cnt + 8'h01;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
    end else if (clk_en) begin
      r <= next_r;
    end
  end

  assign pins.mac_txc_o   = r.ref_clk;
  assign pins.mac_txc_oe  = r.ref_oe;
  assign pins.txd         = r.txd;
  assign pins.txen        = r.txen;
  assign pins.txer        = r.txer;
  assign pins.mdc         = r.mdc;
  assign pins.mac_mdio_o  = r.mdio_o;
  assign pins.mac_mdio_oe = r.mdio_oe;
  assign tx_take   = r.tx_take;
  assign rx_data   = r.rx_data;
  assign rx_valid  = r.rx_valid;
  assign rx_error  = r.rx_error;
  assign rx_strobe = r.rx_strobe;
endmodule : mac_pin_end

// [rtl/phy_pin_end.sv]
/*
  Transceiver end of the MAC-side pins: strap capture after reset, mode
  dependent pin roles, receive clock generation and transmit sampling.
  Assumes rmii_select, speed_100 and the receive user inputs are on sys_clk
  and that every pin input is asynchronous to it.
*/
`timescale 1ns/1ps
`include "pin_mux_defs.svh"
module phy_pin_end (
  // Clock, reset, enable
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       clk_en,
  // Configuration
  input  wire logic       rmii_select,
  input  wire logic       speed_100,
  // Captured straps
  output logic [4:1]      mgmt_address,
  output logic            pcs_loopback,
  output logic            serial_iface_select_strap,
  output logic            isolate,
  output logic            straps_valid,
  // Receive side from the core
  input  wire logic [3:0] rx_data,
  input  wire logic       rx_valid,
  input  wire logic       rx_error,
  output logic            rx_take,
  // Transmit side to the core
  output logic [3:0]      tx_data,
  output logic            tx_en,
  output logic            tx_err,
  output logic            tx_sync,
  output logic            tx_strobe,
  // Management bits sampled on the host clock
  output logic            mgmt_bit,
  output logic            mgmt_strobe,
  // Pins
  mac_phy_pins_if.phy     pins
);
  pin_mux_pkg::phy_regs_type   r;
  pin_mux_pkg::phy_regs_type   next_r;
  pin_mux_pkg::iface_mode_type mode;

  // ----------------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------------
  function automatic pin_mux_pkg::iface_mode_type mode_of(
    input logic serial,
    input logic rmii
  );
    if (serial) begin
      return pin_mux_pkg::MODE_SMII;
    end
    return rmii ? pin_mux_pkg::MODE_RMII : pin_mux_pkg::MODE_MII;
  endfunction : mode_of

  assign mode = mode_of(r.serial_sel, rmii_select);

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    logic       mii;
    logic       run;
    logic       load;
    logic       smp;
    logic [7:0] half;
    logic [6:0] s;
    next_r = r;
    mii    = (mode == pin_mux_pkg::MODE_MII);
    run    = (r.state == pin_mux_pkg::ST_RUN);
    s      = r.strap_s2;
    half   = speed_100 ? `RXC_100_HALF : `RXC_10_HALF;
    load   = 1'b0;
    smp    = 1'b0;

    // Straps are read through two flops, then frozen for good.
    next_r.strap_s1 = {pins.rxer, pins.rxc, pins.rxdv, pins.rxd};
    next_r.strap_s2 = r.strap_s1;
    next_r.ref_s    = {r.ref_s[1:0], pins.txc};
    next_r.tx_s1    = {pins.txer, pins.txen, pins.txd};
    next_r.tx_s2    = r.tx_s1;
    next_r.mdc_s    = {r.mdc_s[1:0], pins.mdc};
    next_r.mdio_s   = {r.mdio_s[0], pins.mdio};

    case (r.state)
      pin_mux_pkg::ST_SETTLE_A: begin
        next_r.state = pin_mux_pkg::ST_SETTLE_B;
      end
      pin_mux_pkg::ST_SETTLE_B: begin
        next_r.state = pin_mux_pkg::ST_LATCH;
      end
      pin_mux_pkg::ST_LATCH: begin
        // Pin rxd[3] is address bit one, rxd[0] is bit four.
        next_r.mgmt_address = {s[0], s[1], s[2], s[3]};
        next_r.pcs_loopback = s[`STRAP_DV_BIT];
        next_r.serial_sel   = s[`STRAP_CLK_BIT];
        next_r.isolate      = s[`STRAP_ERR_BIT];
        next_r.state        = pin_mux_pkg::ST_RUN;
      end
      pin_mux_pkg::ST_RUN: begin
        next_r.state = pin_mux_pkg::ST_RUN;
      end
      default: begin
        next_r.state = pin_mux_pkg::ST_SETTLE_A;
      end
    endcase

    // Output drive starts only once the straps are frozen.
    next_r.rx_oe  = run & !r.isolate;
    next_r.rxc_oe = run & !r.isolate & mii;
    next_r.txc_oe = run & !r.isolate & mii;

    // ----------------------------------------------------------------
    // Link timing: own divider in MII, MAC reference clock otherwise
    // ----------------------------------------------------------------
    if (mii) begin
      if (r.div_cnt >= half - 8'h01) begin
        next_r.div_cnt = 8'h00;
        next_r.rxc     = !r.rxc;
        load = r.rxc;
        smp  = !r.rxc;
      end else begin
        next_r.div_cnt = r.div_cnt + 8'h01;
      end
    end else begin
      next_r.div_cnt = 8'h00;
      next_r.rxc     = 1'b0;
      load = r.ref_s[1] & !r.ref_s[2];
      smp  = load;
    end
    load = load & run;
    smp  = smp & run;

    next_r.rx_take = load;
    if (load) begin
      next_r.rxer = rx_error;
      next_r.rxdv = rx_valid;
      case (mode)
        pin_mux_pkg::MODE_MII: begin
          next_r.rxd = rx_data;
        end
        pin_mux_pkg::MODE_RMII: begin
          next_r.rxd = {2'h0, rx_data[1:0]};
        end
        pin_mux_pkg::MODE_SMII: begin
          next_r.rxd = {3'h0, rx_data[0]};
        end
        default: begin
          next_r.rxd = 4'h0;
        end
      endcase
    end

    next_r.tx_strobe = smp;
    if (smp) begin
      next_r.tx_data = r.tx_s2[3:0];
      next_r.tx_en   = r.tx_s2[4];
      next_r.tx_err  = r.tx_s2[5];
      next_r.tx_sync = (mode == pin_mux_pkg::MODE_SMII) & r.tx_s2[1];
    end

    // ----------------------------------------------------------------
    // Management data follows the host clock's rising edge
    // ----------------------------------------------------------------
    next_r.mgmt_strobe = r.mdc_s[1] & !r.mdc_s[2];
    if (next_r.mgmt_strobe) begin
      next_r.mgmt_bit = r.mdio_s[1];
    end
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      r       <= '0;
      r.state <= pin_mux_pkg::ST_SETTLE_A;
    end else if (clk_en) begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs, all straight from the state register
  // ----------------------------------------------------------------------
  assign pins.phy_rxd_o  = r.rxd;
  assign pins.phy_rxdv_o = r.rxdv;
  assign pins.phy_rxer_o = r.rxer;
  assign pins.phy_rx_oe  = r.rx_oe;
  assign pins.phy_rxc_o  = r.rxc;
  assign pins.phy_rxc_oe = r.rxc_oe;
  assign pins.phy_txc_o  = r.rxc;
  assign pins.phy_txc_oe = r.txc_oe;

  assign mgmt_address              = r.mgmt_address;
  assign pcs_loopback              = r.pcs_loopback;
  assign serial_iface_select_strap = r.serial_sel;
  assign isolate                   = r.isolate;
  assign straps_valid = r.state[3];
  assign rx_take      = r.rx_take;
  assign tx_data      = r.tx_data;
  assign tx_en        = r.tx_en;
  assign tx_err       = r.tx_err;
  assign tx_sync      = r.tx_sync;
  assign tx_strobe    = r.tx_strobe;
  assign mgmt_bit     = r.mgmt_bit;
  assign mgmt_strobe  = r.mgmt_strobe;
endmodule : phy_pin_end

// [rtl/pin_mux_defs.svh]
/*
  Constants shared by both ends of the MAC-side pin multiplexer: clock
  rates, divider half periods and strap field positions.
  Assumes an includer that runs on a 25 MHz system clock.
*/
// Overview of operation
// - Receive data straps become management address bits
// - Receive-valid strap enables coding-sublayer loopback
// - Receive-clock strap selects serial interface mode
// - Receive-error strap selects MAC-side isolation
// - MII receive clock at 25 or 2.5 MHz (here 12.5 MHz at speed_100)
// - MII transmit clock driven out by device
// - RMII: MAC supplies 50 MHz reference clock (here 12.5 MHz)
// - Serial mode: MAC supplies 125 MHz clock (here 12.5 MHz)
// - Host drives management clock, data follows it
// - Receive data width follows interface mode
// - Receive-valid pin meaning follows interface mode (here rxdv carries rx_valid in every mode)
// - Receive error pin flags receive errors
// - MAC drives transmit enable and error
// - Second transmit bit is serial frame sync
`ifndef PIN_MUX_DEFS_SVH
`define PIN_MUX_DEFS_SVH

// ----------------------------------------------------------------------
// Rates in kHz
// ----------------------------------------------------------------------
`define SYS_CLK_KHZ      25000
`define RXC_100_KHZ      25000
`define RXC_10_KHZ       2500
`define RMII_REF_KHZ     50000
`define SMII_REF_KHZ     125000
`define MDC_KHZ          2500

// ----------------------------------------------------------------------
// Half periods in system cycles, rounded down, never below one
// ----------------------------------------------------------------------
`define HALF_CYC(k) (((`SYS_CLK_KHZ / (2 * (k))) < 1) ? 1 : \
                     (`SYS_CLK_KHZ / (2 * (k))))
`define RXC_100_HALF     8'(`HALF_CYC(`RXC_100_KHZ))
`define RXC_10_HALF      8'(`HALF_CYC(`RXC_10_KHZ))
`define RMII_REF_HALF    8'(`HALF_CYC(`RMII_REF_KHZ))
`define SMII_REF_HALF    8'(`HALF_CYC(`SMII_REF_KHZ))
`define MDC_HALF         8'(`HALF_CYC(`MDC_KHZ))

// ----------------------------------------------------------------------
// Strap vector field positions {rx_err, rx_clk, rx_dv, rxd[3:0]}
// ----------------------------------------------------------------------
`define STRAP_DV_BIT     4
`define STRAP_CLK_BIT    5
`define STRAP_ERR_BIT    6

`endif

// [rtl/pin_mux_pkg.sv]
/*
  Types shared by both ends of the pin multiplexer.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package pin_mux_pkg;

  typedef enum logic [1:0] {
    MODE_MII  = 2'h0,
    MODE_RMII = 2'h1,
    MODE_SMII = 2'h2
  } iface_mode_type;

  typedef enum logic [3:0] {
    ST_SETTLE_A = 4'h1,
    ST_SETTLE_B = 4'h2,
    ST_LATCH    = 4'h4,
    ST_RUN      = 4'h8
  } strap_state_type;

  typedef struct packed {
    strap_state_type state;
    logic [7:0]      div_cnt;
    logic            rxc;
    logic [6:0]      strap_s1;
    logic [6:0]      strap_s2;
    logic [2:0]      ref_s;
    logic [5:0]      tx_s1;
    logic [5:0]      tx_s2;
    logic [2:0]      mdc_s;
    logic [1:0]      mdio_s;
    logic [3:0]      mgmt_address;
    logic            pcs_loopback;
    logic            serial_sel;
    logic            isolate;
    logic [3:0]      rxd;
    logic            rxdv;
    logic            rxer;
    logic            rx_oe;
    logic            rxc_oe;
    logic            txc_oe;
    logic            rx_take;
    logic [3:0]      tx_data;
    logic            tx_en;
    logic            tx_err;
    logic            tx_sync;
    logic            tx_strobe;
    logic            mgmt_bit;
    logic            mgmt_strobe;
  } phy_regs_type;

  typedef struct packed {
    logic [7:0] ref_cnt;
    logic       ref_clk;
    logic       ref_oe;
    logic [2:0] txc_s;
    logic [2:0] rxc_s;
    logic [5:0] rx_s1;
    logic [5:0] rx_s2;
    logic [3:0] txd;
    logic       txen;
    logic       txer;
    logic       tx_take;
    logic [7:0] mdc_cnt;
    logic       mdc;
    logic       mdio_o;
    logic       mdio_oe;
    logic [3:0] rx_data;
    logic       rx_valid;
    logic       rx_error;
    logic       rx_strobe;
  } mac_regs_type;

endpackage : pin_mux_pkg
